// >>> bench/fanout_router_tb.sv
`timescale 1ns/1ps
module fanout_router_tb;
  localparam int DEPTH = 128;
  typedef struct packed {
    logic by_id; logic [15:0] id; logic [31:0] addr; logic [2:0] tgt;
  } row_type;
  typedef struct packed {
    logic [3:0] conn, hs, ehci, o0, o1; logic [7:0] fn;
  } usb_type;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, aux_rst_n_i = 1'b0;
  logic        store_forward_i = 1'b0, sticky_clear_i = 1'b0;
  logic        dn_valid_i = 1'b0, dn_sop_i = 1'b0, dn_eop_i = 1'b0;
  logic        dn_by_id_i = 1'b0, up_valid_i = 1'b0, up_eop_i = 1'b0;
  logic [1:0]  dn_kind_i = 2'h0;
  logic [2:0]  dn_tc_i = 3'h0;
  logic [15:0] dn_id_i = 16'h0000;
  logic [31:0] dn_addr_i = 32'h0, dn_data_i = 32'h0, up_data_i = 32'h0;
  logic [3:0]  usb_connect_i = 4'h0, usb_hs_i = 4'h0;
  logic [2:1]  ds_reset_req_i = 2'h0;
  logic        eg_ready_i = 1'b0, eg_hold = 1'b0, eg_slow = 1'b0;
  logic        rc_slow = 1'b0, us_ready_i;
  logic [7:0]  ds1_bus_lo_i, ds1_bus_hi_i, ds2_bus_lo_i, ds2_bus_hi_i;
  logic [7:0]  usb_bus_i, port_fn_o;
  logic [4:0]  usb_dev_i;
  logic [31:0] win_base_i [router_pkg::NUM_WIN];
  logic [31:0] win_limit_i [router_pkg::NUM_WIN];
  logic        dn_ready_o, eg_valid_o, eg_eop_o, up_ready_o, us_valid_o;
  logic        us_eop_o, drop_seen_o, saf_mode_o;
  logic [31:0] eg_data_o, us_data_o;
  logic [2:0]  eg_target_o;
  logic [3:0]  ehci_ports_o, ohci0_ports_o, ohci1_ports_o;
  logic [2:1]  downstream_port_reset_n_o;
  int          bad_count = 0, total_checks = 0, refused = 0, n;
  logic [35:0] eg_q [$];
  row_type     rows [12] = '{
    '{1'b1, 16'h0200, 32'h0, 3'h0}, '{1'b1, 16'h0300, 32'h0, 3'h0},
    '{1'b1, 16'h0400, 32'h0, 3'h1}, '{1'b1, 16'h0500, 32'h0, 3'h1},
    '{1'b1, 16'h0600, 32'h0, 3'h2}, '{1'b1, 16'h0601, 32'h0, 3'h3},
    '{1'b1, 16'h0602, 32'h0, 3'h4}, '{1'b0, 16'h0, 32'h1000_0000, 3'h0},
    '{1'b0, 16'h0, 32'h101F_FFFF, 3'h1}, '{1'b0, 16'h0, 32'h102F_FFFF, 3'h2},
    '{1'b0, 16'h0, 32'h1030_0000, 3'h3}, '{1'b0, 16'h0, 32'h104F_FFFF, 3'h4}};
  usb_type     urows [4] = '{
    '{4'hF, 4'h0, 4'h0, 4'h3, 4'hC, 8'h50},
    '{4'hF, 4'hF, 4'hF, 4'h0, 4'h0, 8'hAA},
    '{4'hF, 4'h5, 4'h5, 4'h2, 4'h8, 8'h62},
    '{4'h6, 4'h4, 4'h4, 4'h2, 4'h0, 8'h00}};

  fanout_router #(.DEPTH(DEPTH)) u_dut (.*);
  root_complex_model u_rc (
    .sys_clk_i(sys_clk_i), .slow_i(rc_slow), .us_valid_i(us_valid_o),
    .us_data_i(us_data_o), .us_eop_i(us_eop_o), .us_ready_o(us_ready_i),
    .ds1_lo_o(ds1_bus_lo_i), .ds1_hi_o(ds1_bus_hi_i),
    .ds2_lo_o(ds2_bus_lo_i), .ds2_hi_o(ds2_bus_hi_i),
    .usb_bus_o(usb_bus_i), .usb_dev_o(usb_dev_i),
    .win_base_o(win_base_i), .win_limit_o(win_limit_i));

  ////////////////////////////////////////////////////////////////////////
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (eg_valid_o === 1'b1 && eg_ready_i === 1'b1) begin
      eg_q.push_back({eg_target_o, eg_eop_o, eg_data_o});
    end
    if (dn_valid_i === 1'b1 && dn_ready_o === 1'b0) refused++;
    if (refused >= 8) eg_hold <= 1'b0;
    eg_ready_i <= !eg_hold && (!eg_slow || !eg_ready_i);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag got %b want %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic dn_hdr(input logic b, input logic [15:0] id,
                        input logic [31:0] a, input int r);
    dn_by_id_i <= b;
    dn_id_i <= id;
    dn_addr_i <= a;
    dn_tc_i <= 3'(r);
    dn_kind_i <= 2'(r % 3);
  endtask
  task automatic dn_beat(input logic s, input logic e, input int d);
    dn_valid_i <= 1'b1;
    dn_sop_i <= s;
    dn_eop_i <= e;
    dn_data_i <= 32'(d);
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk_i);
      if (dn_ready_o === 1'b1) break;
    end
  endtask
  task automatic up_beat(input logic e, input int d);
    up_valid_i <= 1'b1;
    up_eop_i <= e;
    up_data_i <= 32'(d);
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk_i);
      if (up_ready_o === 1'b1) break;
    end
  endtask
  task automatic wait_eg(input int cnt);
    for (int i = 0; i < 3000 && eg_q.size() < cnt; i++) tick(1);
  endtask
  task automatic part_pkt(input logic saf);
    store_forward_i <= saf;
    for (int i = 0; i < 20 && saf_mode_o !== saf; i++) tick(1);
    chk_flag(saf_mode_o, saf);
    dn_hdr(1'b1, 16'h0400, 32'h0, 1);
    dn_beat(1'b1, 1'b0, 1);
    dn_beat(1'b0, 1'b0, 2);
    dn_valid_i <= 1'b0;
    tick(6);
    chk_word(36'(eg_q.size()), saf ? 36'h0 : 36'h2);
    dn_beat(1'b0, 1'b1, 3);
    dn_valid_i <= 1'b0;
    wait_eg(3);
    for (int i = 1; i <= 3; i++) begin
      chk_word(eg_q.pop_front(), {3'h1, i == 3, 32'(i)});
    end
    $display("test mode %0d done", saf);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    aux_rst_n_i <= 1'b1;
    tick(4);
    chk_word({dn_ready_o, eg_valid_o, us_valid_o, up_ready_o, saf_mode_o,
              drop_seen_o}, 36'h24);
    chk_word(downstream_port_reset_n_o, 2'h0);
    rst_n_i <= 1'b1;
    for (n = 0; n < 60 && downstream_port_reset_n_o !== 2'h3; n++) tick(1);
    chk_flag(n >= 26 && n <= 28, 1'b1);
    chk_flag(saf_mode_o, 1'b0);
    $display("test reset done");
    for (int r = 0; r < 12; r++) begin
      dn_hdr(rows[r].by_id, rows[r].id, rows[r].addr, r);
      dn_beat(1'b1, 1'b1, 32'hA500_0000 + r);
      dn_valid_i <= 1'b0;
      wait_eg(1);
      chk_word(eg_q.pop_front(), {rows[r].tgt, 1'b1,
               32'hA500_0000 + 32'(r)});
    end
    $display("test routing done");
    for (int u = 0; u < 4; u++) begin
      usb_connect_i <= urows[u].conn;
      usb_hs_i <= urows[u].hs;
      tick(8);
      chk_word({ehci_ports_o, ohci0_ports_o, ohci1_ports_o},
               {urows[u].ehci, urows[u].o0, urows[u].o1});
      if (urows[u].conn == 4'hF) chk_word(port_fn_o, urows[u].fn);
    end
    $display("test usb done");
    part_pkt(1'b0);
    part_pkt(1'b1);
    store_forward_i <= 1'b0;
    dn_hdr(1'b1, 16'h0900, 32'h0, 0);
    dn_beat(1'b1, 1'b1, 32'hDEAD_0000);
    dn_valid_i <= 1'b0;
    for (int i = 0; i < 20 && drop_seen_o !== 1'b1; i++) tick(1);
    tick(4);
    chk_flag(drop_seen_o, 1'b1);
    chk_word(36'(eg_q.size()), 36'h0);
    rst_n_i <= 1'b0;
    tick(4);
    rst_n_i <= 1'b1;
    tick(2);
    chk_flag(drop_seen_o, 1'b1);
    sticky_clear_i <= 1'b1;
    tick(2);
    sticky_clear_i <= 1'b0;
    tick(2);
    chk_flag(drop_seen_o, 1'b0);
    tick(30);
    ds_reset_req_i <= 2'h2;
    tick(2);
    chk_word(downstream_port_reset_n_o, 2'h1);
    ds_reset_req_i <= 2'h0;
    tick(30);
    chk_word(downstream_port_reset_n_o, 2'h3);
    $display("test sticky and resets done");
    refused = 0;
    eg_hold <= 1'b1;
    eg_slow <= 1'b1;
    dn_hdr(1'b1, 16'h0200, 32'h0, 2);
    for (int i = 0; i < DEPTH + 12; i++) dn_beat(1'b1, 1'b1, i);
    dn_valid_i <= 1'b0;
    wait_eg(DEPTH + 12);
    chk_flag(refused >= 8, 1'b1);
    for (int i = 0; i < DEPTH + 12; i++) begin
      chk_word(eg_q.pop_front(), {3'h0, 1'b1, 32'(i)});
    end
    eg_slow <= 1'b0;
    $display("test fill done");
    rc_slow <= 1'b1;
    for (int i = 0; i < 6; i++) up_beat(i == 5, 32'hC000_0000 + i);
    up_valid_i <= 1'b0;
    for (int i = 0; i < 200 && u_rc.got_q.size() < 6; i++) tick(1);
    for (int i = 0; i < 6; i++) begin
      chk_word(u_rc.got_q.pop_front(),
               {i == 5, 32'hC000_0000 + 32'(i)});
    end
    $display("test upstream done");
    final_report();
  end

  initial begin
    tick(30000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule // fanout_router_tb

// >>> bench/root_complex_model.sv
`timescale 1ns/1ps
// Host side of the upstream port: it hands out the enumeration results and
// drains upstream-bound words, every other cycle when slow_i is high.
module root_complex_model (
  input  wire logic        sys_clk_i,
  input  wire logic        slow_i,
  input  wire logic        us_valid_i,
  input  wire logic [31:0] us_data_i,
  input  wire logic        us_eop_i,
  output logic             us_ready_o,
  output logic [7:0]       ds1_lo_o,
  output logic [7:0]       ds1_hi_o,
  output logic [7:0]       ds2_lo_o,
  output logic [7:0]       ds2_hi_o,
  output logic [7:0]       usb_bus_o,
  output logic [4:0]       usb_dev_o,
  output logic [31:0]      win_base_o [router_pkg::NUM_WIN],
  output logic [31:0]      win_limit_o [router_pkg::NUM_WIN]
);
  logic [32:0] got_q [$];

  ////////////////////////////////////////////////////////////////////////
  assign ds1_lo_o  = 8'h02;
  assign ds1_hi_o  = 8'h03;
  assign ds2_lo_o  = 8'h04;
  assign ds2_hi_o  = 8'h05;
  assign usb_bus_o = 8'h06;
  assign usb_dev_o = 5'h00;

  // Windows never overlap, so priority inside the router is not exercised.
  always_comb begin
    for (int i = 0; i < router_pkg::NUM_WIN; i++) begin
      win_base_o[i]  = 32'h1000_0000 + (32'(i) << 20);
      win_limit_o[i] = win_base_o[i] + 32'h000F_FFFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial us_ready_o = 1'b0;
  always @(posedge sys_clk_i) begin
    us_ready_o <= slow_i ? ~us_ready_o : 1'b1;
    if (us_valid_i && us_ready_o) begin
      got_q.push_back({us_eop_i, us_data_i});
    end
  end
endmodule // root_complex_model

// >>> hdl/fanout_router.sv
`timescale 1ns/1ps
// Behaviour
// [RULE1] One x1 upstream feeds two x1 downstream ports and four USB ports.
// [RULE2] Store-and-forward holds whole packets; cut-through forwards at once.
// [RULE3] All eight traffic classes share one virtual channel queue.
// [RULE4] Posted, non-posted and completions flow both directions at once.
// [RULE5] One upstream bridge over internal bus; downstream bridges below it.
// [RULE6] Three USB controllers sit behind one internal downstream port.
// [RULE7] Host assigns bus, device, function; these form the routing ID.
// [RULE8] USB controllers share one device: full-speed fn 0, 1; high fn 2.
// [RULE9] Exclusive windows; each packet goes to exactly one target.
// [RULE10] High-speed traffic on any USB port goes to function 2.
// [RULE11] Full/low speed: ports 1,2 to function 0; ports 3,4 to 1.
// [RULE12] Root hub links each controller to its ports and tracks sessions.
// [RULE13] System reset clears all state except sticky logic.
// [RULE14] One active-low reset per downstream port, low during system reset.
// [RULE15] Cut-through after reset; store-and-forward chosen explicitly.
// [RULE16] Packets carry payloads of up to 256 bytes.
// [RULE17] Downstream resets release only after the system reset releases.
module fanout_router #(
  parameter int DEPTH = 128
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        aux_rst_n_i,
  input  wire logic        store_forward_i,
  input  wire logic [7:0]  ds1_bus_lo_i,
  input  wire logic [7:0]  ds1_bus_hi_i,
  input  wire logic [7:0]  ds2_bus_lo_i,
  input  wire logic [7:0]  ds2_bus_hi_i,
  input  wire logic [7:0]  usb_bus_i,
  input  wire logic [4:0]  usb_dev_i,
  input  wire logic [31:0] win_base_i [router_pkg::NUM_WIN],
  input  wire logic [31:0] win_limit_i [router_pkg::NUM_WIN],
  input  wire logic        dn_valid_i,
  output logic             dn_ready_o,
  input  wire logic [31:0] dn_data_i,
  input  wire logic        dn_sop_i,
  input  wire logic        dn_eop_i,
  input  wire logic [1:0]  dn_kind_i,
  input  wire logic [2:0]  dn_tc_i,
  input  wire logic        dn_by_id_i,
  input  wire logic [15:0] dn_id_i,
  input  wire logic [31:0] dn_addr_i,
  output logic             eg_valid_o,
  input  wire logic        eg_ready_i,
  output logic [31:0]      eg_data_o,
  output logic             eg_eop_o,
  output logic [2:0]       eg_target_o,
  input  wire logic        up_valid_i,
  output logic             up_ready_o,
  input  wire logic [31:0] up_data_i,
  input  wire logic        up_eop_i,
  output logic             us_valid_o,
  input  wire logic        us_ready_i,
  output logic [31:0]      us_data_o,
  output logic             us_eop_o,
  input  wire logic [3:0]  usb_connect_i,
  input  wire logic [3:0]  usb_hs_i,
  output logic [7:0]       port_fn_o,
  output logic [3:0]       ehci_ports_o,
  output logic [3:0]       ohci0_ports_o,
  output logic [3:0]       ohci1_ports_o,
  input  wire logic [2:1]  ds_reset_req_i,
  output logic [2:1]       downstream_port_reset_n_o,
  input  wire logic        sticky_clear_i,
  output logic             drop_seen_o,
  output logic             saf_mode_o
);

  localparam int AW   = $clog2(DEPTH);
  localparam int EW   = router_pkg::DATA_W + 4;
  localparam int HW   = $clog2(router_pkg::DS_RST_HOLD_CYC + 1);
  localparam logic [HW-1:0] HOLD = HW'(router_pkg::DS_RST_HOLD_CYC);
  localparam logic [AW:0] MAXW = (AW+1)'(router_pkg::MAX_PKT_WORDS);

  if (DEPTH < router_pkg::MAX_PKT_WORDS || DEPTH != (1 << AW)) begin : g_chk
    $error("DEPTH must be a power of two holding a full packet");
  end

  function automatic logic in_win(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_bus(input logic [7:0] b,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (b >= lo) && (b <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Routing decode on the first beat of a downstream-bound packet.

  wire [7:0] id_bus = dn_id_i[15:router_pkg::BUS_LSB];
  wire [4:0] id_dev = dn_id_i[router_pkg::BUS_LSB-1:router_pkg::DEV_LSB];
  wire [2:0] id_fn  = dn_id_i[router_pkg::DEV_LSB-1:0];
  wire id_ds1 = in_bus(id_bus, ds1_bus_lo_i, ds1_bus_hi_i); // [RULE5]
  wire id_ds2 = in_bus(id_bus, ds2_bus_lo_i, ds2_bus_hi_i); // [RULE5]
  wire id_usb = id_bus == usb_bus_i && id_dev == usb_dev_i; // [RULE6] [RULE8]
  logic [router_pkg::NUM_WIN-1:0] addr_hit;
  for (genvar w = 0; w < router_pkg::NUM_WIN; w++) begin : g_win
    assign addr_hit[w] = in_win(dn_addr_i, win_base_i[w], win_limit_i[w]);
  end

  router_pkg::target_type id_tgt;
  router_pkg::target_type addr_tgt;
  router_pkg::target_type route_tgt;
  router_pkg::target_type cur_tgt;
  router_pkg::target_type beat_tgt;

  // The traffic class is never looked at: every class lands in one queue.
  assign id_tgt = id_ds1 ? router_pkg::TGT_DS1 : // [RULE7] [RULE3]
                  id_ds2 ? router_pkg::TGT_DS2 :
                  !id_usb ? router_pkg::TGT_DROP :
                  id_fn == router_pkg::FN_OHCI_A ? router_pkg::TGT_FN0 :
                  id_fn == router_pkg::FN_OHCI_B ? router_pkg::TGT_FN1 :
                  id_fn == router_pkg::FN_EHCI ? router_pkg::TGT_FN2 :
                  router_pkg::TGT_DROP;
  // Windows are exclusive once enumerated; lowest index wins otherwise.
  assign addr_tgt = addr_hit[0] ? router_pkg::TGT_DS1 : // [RULE9]
                    addr_hit[1] ? router_pkg::TGT_DS2 :
                    addr_hit[2] ? router_pkg::TGT_FN0 :
                    addr_hit[3] ? router_pkg::TGT_FN1 :
                    addr_hit[4] ? router_pkg::TGT_FN2 :
                    router_pkg::TGT_DROP;
  assign route_tgt = dn_by_id_i ? id_tgt : addr_tgt;
  assign beat_tgt  = dn_sop_i ? route_tgt : cur_tgt;

  ////////////////////////////////////////////////////////////////////////////
  // Packet queue toward the downstream side.

  logic [EW-1:0] mem [DEPTH];
  logic [AW:0]   wptr;
  logic [AW:0]   rptr;
  logic [AW:0]   wcount;
  logic [AW:0]   pkt_cnt;
  router_pkg::fwd_mode_type mode;

  stream_if #(.W(EW)) q_s ();
  stream_if #(.W(EW)) eg_s ();

  wire q_empty = wptr == rptr;
  wire q_full  = (wptr ^ rptr) == {1'b1, {AW{1'b0}}};
  wire drop_pkt = beat_tgt == router_pkg::TGT_DROP;
  wire too_long = wcount >= MAXW && !dn_eop_i;
  wire dn_fire  = dn_valid_i && dn_ready_o;
  wire wr_en    = dn_fire && !drop_pkt && !too_long; // [RULE16]
  wire drop_ev  = dn_fire && (drop_pkt || too_long);
  wire rd_ok    = mode == router_pkg::MODE_SAF ? pkt_cnt != '0 // [RULE2]
                                               : !q_empty;
  wire rd_fire  = q_s.valid && q_s.ready;
  wire wr_last  = wr_en && dn_eop_i;
  wire rd_last  = rd_fire && q_s.data[EW-1];

  assign dn_ready_o = !q_full || drop_pkt;
  assign q_s.valid  = rd_ok;
  assign q_s.data   = mem[rptr[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en) begin
      mem[wptr[AW-1:0]] <= {dn_eop_i, beat_tgt, dn_data_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin // [RULE13]
      wptr    <= '0;
      rptr    <= '0;
      wcount  <= '0;
      pkt_cnt <= '0;
      cur_tgt <= router_pkg::TGT_DROP;
    end else begin
      if (wr_en) wptr <= wptr + 1'b1;
      if (rd_fire) rptr <= rptr + 1'b1;
      pkt_cnt <= pkt_cnt + {{AW{1'b0}}, wr_last} - {{AW{1'b0}}, rd_last};
      if (dn_fire) begin
        cur_tgt <= beat_tgt;
        wcount  <= dn_eop_i ? '0 : (dn_sop_i ? (AW+1)'(1) : wcount + 1'b1);
      end
    end
  end

  // A mode change waits only for an empty queue, not for a packet boundary, so
  // a packet still being written can be split between the two release policies.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode <= router_pkg::MODE_CUT; // [RULE15]
    end else if (q_empty) begin
      mode <= store_forward_i ? router_pkg::MODE_SAF : router_pkg::MODE_CUT;
    end
  end
  assign saf_mode_o = mode == router_pkg::MODE_SAF;

  hold_buffer #(.W(EW)) u_eg_buf (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .in_s      (q_s),
    .out_s     (eg_s)
  );
  assign eg_valid_o  = eg_s.valid; // [RULE1] [RULE9]
  assign eg_s.ready  = eg_ready_i;
  assign eg_data_o   = eg_s.data[31:0];
  assign eg_target_o = eg_s.data[34:32];
  assign eg_eop_o    = eg_s.data[EW-1];

  ////////////////////////////////////////////////////////////////////////////
  // Upstream-bound path runs beside the downstream queue.

  stream_if #(.W(33)) up_s ();
  stream_if #(.W(33)) us_s ();
  assign up_s.valid = up_valid_i; // [RULE4]
  assign up_s.data  = {up_eop_i, up_data_i};
  assign up_ready_o = up_s.ready;
  hold_buffer #(.W(33)) u_us_buf (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .in_s      (up_s),
    .out_s     (us_s)
  );
  assign us_valid_o = us_s.valid;
  assign us_s.ready = us_ready_i;
  assign us_data_o  = us_s.data[31:0];
  assign us_eop_o   = us_s.data[32];

  ////////////////////////////////////////////////////////////////////////////
  // Root hub: pin synchronisers and controller ownership of ports.

  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  logic [7:0] pin_st;
  wire  [3:0] conn_st = pin_st[3:0];
  wire  [3:0] hs_st   = pin_st[7:4];
  wire  [3:0] fs_st   = conn_st & ~hs_st;
  logic [7:0] next_port_fn;

  always_comb begin
    next_port_fn = '0;
    for (int p = 0; p < router_pkg::USB_PORTS; p++) begin
      next_port_fn[2*p +: 2] = hs_st[p] ? router_pkg::FN_EHCI[1:0] // [RULE10]
                             : router_pkg::OHCI_B_PORTS[p]
                             ? router_pkg::FN_OHCI_B[1:0] // [RULE11]
                             : router_pkg::FN_OHCI_A[1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_s1        <= '0;
      pin_s2        <= '0;
      pin_s3        <= '0;
      pin_st        <= '0;
      port_fn_o     <= '0;
      ehci_ports_o  <= '0;
      ohci0_ports_o <= '0;
      ohci1_ports_o <= '0;
    end else begin
      pin_s1        <= {usb_hs_i, usb_connect_i};
      pin_s2        <= pin_s1;
      pin_s3        <= pin_s2;
      pin_st        <= (pin_s2 & pin_s3) | (pin_st & (pin_s2 | pin_s3));
      port_fn_o     <= next_port_fn;
      ehci_ports_o  <= conn_st & hs_st; // [RULE12] [RULE10]
      ohci0_ports_o <= fs_st & router_pkg::OHCI_A_PORTS; // [RULE11]
      ohci1_ports_o <= fs_st & router_pkg::OHCI_B_PORTS; // [RULE11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Downstream resets and sticky drop flag.

  logic [HW-1:0] hold_cnt [1:2];
  for (genvar d = 1; d <= 2; d++) begin : g_dsr
    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || ds_reset_req_i[d]) begin // [RULE14]
        hold_cnt[d] <= '0;
        downstream_port_reset_n_o[d] <= 1'b0;
      end else begin
        if (hold_cnt[d] != HOLD) hold_cnt[d] <= hold_cnt[d] + 1'b1;
        downstream_port_reset_n_o[d] <= hold_cnt[d] == HOLD; // [RULE17]
      end
    end
  end
  // Survives the system reset so software can see why packets vanished.
  always_ff @(posedge sys_clk_i) begin
    if (!aux_rst_n_i) begin
      drop_seen_o <= 1'b0;
    end else if (drop_ev) begin // [RULE13]
      drop_seen_o <= 1'b1;
    end else if (sticky_clear_i) begin
      drop_seen_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [5:0] since_rst;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) since_rst <= '0;
    else if (since_rst != 6'h3F) since_rst <= since_rst + 1'b1;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!aux_rst_n_i);

  chk_reset_low: assert property ( // [RULE14]
    !rst_n_i |=> downstream_port_reset_n_o == 2'h0
  ) else $error("downstream reset not low during system reset");
  chk_reset_late: assert property ( // [RULE17]
    downstream_port_reset_n_o[1] |-> since_rst > 6'd25
  ) else $error("downstream reset released too early");
  chk_mode_cut: assert property ( // [RULE15]
    $rose(rst_n_i) |-> !saf_mode_o
  ) else $error("forwarding mode after reset is not cut-through");
  chk_saf_whole: assert property ( // [RULE2]
    disable iff (!rst_n_i) saf_mode_o && rd_fire |-> pkt_cnt != '0
  ) else $error("partial packet released in store-and-forward");
  chk_cut_flow: assert property ( // [RULE2]
    disable iff (!rst_n_i)
    !saf_mode_o && !q_empty && q_s.ready |-> rd_fire
  ) else $error("cut-through stalled with data queued");
  chk_id_ds1: assert property ( // [RULE7]
    disable iff (!rst_n_i)
    dn_fire && dn_sop_i && dn_by_id_i && id_ds1 |->
    ##1 cur_tgt == router_pkg::TGT_DS1
  ) else $error("ID routed packet missed downstream port 1");
  chk_usb_fn2: assert property ( // [RULE8]
    dn_by_id_i && id_usb && !id_ds1 && !id_ds2 && id_fn == 3'h2 |->
    route_tgt == router_pkg::TGT_FN2
  ) else $error("function 2 not steered to high-speed controller");
  chk_drop_gone: assert property ( // [RULE9]
    drop_pkt |-> !wr_en
  ) else $error("unroutable beat entered the queue");
  chk_port_owner: assert property ( // [RULE11]
    disable iff (!rst_n_i)
    (ehci_ports_o & (ohci0_ports_o | ohci1_ports_o)) == 4'h0 &&
    ohci0_ports_o[3:2] == 2'h0 && ohci1_ports_o[1:0] == 2'h0
  ) else $error("USB port owned by wrong controller");
  chk_sticky_set: assert property ( // [RULE13]
    drop_ev |=> drop_seen_o
  ) else $error("drop event lost on sticky flag");

  cov_saf_pkt: cover property (saf_mode_o && rd_last);
  cov_cut_pkt: cover property (!saf_mode_o && rd_last);
  cov_fn2_hit: cover property (dn_fire && beat_tgt == router_pkg::TGT_FN2);
  cov_stall: cover property (eg_valid_o && !eg_ready_i ##1 !q_s.ready);

endmodule // fanout_router

// >>> hdl/hold_buffer.sv
`timescale 1ns/1ps
module hold_buffer #(
  parameter int W = 32
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  stream_if.snk     in_s,
  stream_if.src     out_s
);

  // Two entries let the source see ready a full cycle late without loss.
  logic [W-1:0] slot [2];
  logic         wr_sel;
  logic         rd_sel;
  logic [1:0]   count;
  wire          push = in_s.valid && in_s.ready;
  wire          pop  = out_s.valid && out_s.ready;

  assign in_s.ready  = count != 2'h2;
  assign out_s.valid = count != 2'h0;
  assign out_s.data  = slot[rd_sel];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      slot[wr_sel] <= in_s.data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_sel <= 1'b0;
      rd_sel <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_sel <= !wr_sel;
      if (pop) rd_sel <= !rd_sel;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // hold_buffer

// >>> shared/router_pkg.sv
package router_pkg;

  localparam int DATA_W            = 32;
  localparam int ID_W              = 16;
  localparam int BUS_LSB           = 8;
  localparam int DEV_LSB           = 3;
  localparam int TC_W              = 3;
  localparam int NUM_TC            = 8;
  localparam int MAX_PAYLOAD_BYTES = 256;
  localparam int HDR_WORDS         = 4;
  localparam int MAX_PKT_WORDS     = MAX_PAYLOAD_BYTES / 4 + HDR_WORDS;
  localparam int USB_PORTS         = 4;
  localparam int NUM_WIN           = 5;

  localparam logic [2:0] FN_OHCI_A = 3'h0;
  localparam logic [2:0] FN_OHCI_B = 3'h1;
  localparam logic [2:0] FN_EHCI   = 3'h2;
  localparam logic [3:0] OHCI_A_PORTS = 4'h3;
  localparam logic [3:0] OHCI_B_PORTS = 4'hC;

  localparam int CLK_PERIOD_PS   = 4000;
  localparam int DS_RST_HOLD_NS  = 100;
  localparam int DS_RST_HOLD_CYC =
    (DS_RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    TGT_DS1, TGT_DS2, TGT_FN0, TGT_FN1, TGT_FN2, TGT_DROP
  } target_type;

  typedef enum logic [1:0] {
    KIND_POSTED, KIND_NONPOSTED, KIND_CPL
  } kind_type;

  typedef enum logic {MODE_CUT, MODE_SAF} fwd_mode_type;

endpackage

// >>> shared/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
